// file: dsp_adder_pkg.sv
/*
  Constants, field layouts and types for the adder/output stage of the hard multiplier block.
  Assumes products arrive as 36-bit 2.34 values and that all logic runs on one 100 MHz clock.

*/
package dsp_adder_pkg;
  localparam int          PROD_W     = 36;
  localparam int          ACC_W      = 52;
  localparam int          RES_W      = 72;
  localparam int          PRE_SHIFT  = 16;
  localparam logic [71:0] RND_ADD    = 72'h000000000000040000;
  localparam logic [71:0] RND_MASK   = 72'h00000000000007ffff;
  localparam logic [71:0] LOW3_MASK  = 72'h000000000000000007;
  localparam logic [71:0] SAT_POS    = 72'h0000000003fffffff8;
  localparam logic [71:0] SAT_NEG    = 72'hfffffffffc00000000;
  localparam int          SAT_TOP    = 34;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_ACCCFG = 8'h04;
  localparam logic [7:0]  OFS_OREG   = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0c;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  localparam logic [31:0] ACCCFG_RST = 32'h0000000a;
  localparam logic [31:0] OREG_RST   = 32'h00000000;
  // Field positions: CTRL
  localparam int          CTRL_MODE  = 0;
  localparam int          CTRL_SIZE  = 4;
  // Field positions: ACCCFG
  localparam int          CFG_DIR0   = 0;
  localparam int          CFG_DIR1   = 2;
  localparam int          CFG_SPIPE  = 4;
  localparam int          CFG_DPIPE  = 6;
  // Field positions: OREG (per register, stride 8)
  localparam int          OREG_STR   = 8;
  localparam int          OREG_CLK   = 0;
  localparam int          OREG_ENA   = 2;
  localparam int          OREG_CLR   = 4;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {MODE_SIMPLE, MODE_MAC, MODE_ADD2, MODE_ADD4, MODE_MUL36} outMode_t;
  typedef enum logic [1:0] {SIZE_18, SIZE_9, SIZE_36} mulSize_t;
  typedef enum logic [1:0] {DIR_ADD, DIR_SUB, DIR_DYN} accDir_t;
endpackage

// file: dsp_adder_output_stage.sv
/*
  Adder/output stage: first-level adders, summation adder, accumulators, output select and
  output registers, with an AXI4-Lite slave for configuration and status.
  Assumes products come from the multiplier stage and fabric drives the dynamic controls.
*/
`timescale 1ns/1ns
module dsp_adder_output_stage
  import dsp_adder_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [PROD_W-1:0] prod0,
  input  wire logic [PROD_W-1:0] prod1,
  input  wire logic [PROD_W-1:0] prod2,
  input  wire logic [PROD_W-1:0] prod3,
  input  wire logic              signA,
  input  wire logic              signB,
  input  wire logic              topAdderDirection,
  input  wire logic              bottomAdderDirection,
  input  wire logic              topAdderRoundEnable,
  input  wire logic              bottomAdderRoundEnable,
  input  wire logic [1:0]        accSload,
  input  wire logic [PROD_W-1:0] accPreload0,
  input  wire logic [PROD_W-1:0] accPreload1,
  input  wire logic [1:0]        accRoundEnable,
  input  wire logic [1:0]        accSatEnable,
  input  wire logic [3:0]        clockTick,
  input  wire logic [3:0]        clockEna,
  input  wire logic [3:0]        clearIn,
  output logic [RES_W-1:0]       result0,
  output logic [RES_W-1:0]       result1,
  output logic [1:0]             accOverflow,
  output logic [1:0]             accSatFlag
);

  // Extend a product to 72 bits, signed when either operand is signed
  function automatic logic [71:0] extProd(input logic [35:0] p, input logic sgn);
    extProd = {{36{sgn & p[35]}}, p};
  endfunction

  // Add or subtract two extended values, optionally rounding to Q1.15
  function automatic logic [71:0] addSub(input logic [71:0] a, input logic [71:0] b,
                                         input logic add, input logic rnd);
    logic [71:0] s;
    s = add ? a + b : a - b;
    addSub = rnd ? ((s + RND_ADD) & ~RND_MASK) : s;
  endfunction

  // Half-width add for narrow mode: two 18-bit products packed in each 36-bit slot
  function automatic logic [35:0] addHalf(input logic [17:0] a, input logic [17:0] b,
                                          input logic add, input logic sgn);
    logic [35:0] ea;
    logic [35:0] eb;
    ea = {{18{sgn & a[17]}}, a};
    eb = {{18{sgn & b[17]}}, b};
    addHalf = add ? ea + eb : ea - eb;
  endfunction

  // Configuration and status registers
  logic [31:0] ctrl_r;
  logic [31:0] accCfg_r;
  logic [31:0] oregCfg_r;
  logic [1:0]  satSeen_r;
  logic [1:0]  ovfSeen_r;

  // AXI4-Lite write path: address and data taken in either order
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  wire         awTake   = awvalid & awready;
  wire         wTake    = wvalid & wready;
  wire         doWrite  = awHeld_r & wHeld_r & ~bvalid;
  wire         wrMapped = (awAddr_r == OFS_CTRL) | (awAddr_r == OFS_ACCCFG) | (awAddr_r == OFS_OREG)
                          | (awAddr_r == OFS_STATUS);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= 8'h00;
      wData_r   <= 32'h00000000;
      wStrb_r   <= 4'h0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      ctrl_r    <= CTRL_RST;
      accCfg_r  <= ACCCFG_RST;
      oregCfg_r <= OREG_RST;
    end else begin
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {awaddr[7:2], 2'b00};
        awready  <= 1'b0;
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
        wready  <= 1'b0;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        if (awAddr_r == OFS_CTRL)   ctrl_r    <= merge(ctrl_r, wData_r, wStrb_r);
        if (awAddr_r == OFS_ACCCFG) accCfg_r  <= merge(accCfg_r, wData_r, wStrb_r);
        if (awAddr_r == OFS_OREG)   oregCfg_r <= merge(oregCfg_r, wData_r, wStrb_r);
      end else if (bvalid & bready) begin
        // Both channels reopen only once the response is accepted
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Status register read clears sticky bits; a new event in the same cycle wins
  wire        statusRead = arvalid & arready & ({araddr[7:2], 2'b00} == OFS_STATUS);
  wire [31:0] statusWord = {26'h0, ovfSeen_r, satSeen_r, accSatFlag};
  logic [31:0] rdSel;
  always_comb begin
    rdSel = 32'h00000000;
    unique case ({araddr[7:2], 2'b00})
      OFS_CTRL:   rdSel = ctrl_r;
      OFS_ACCCFG: rdSel = accCfg_r;
      OFS_OREG:   rdSel = oregCfg_r;
      OFS_STATUS: rdSel = statusWord;
      default:    rdSel = 32'h00000000;
    endcase
  end
  wire rdMapped = ({araddr[7:2], 2'b00} <= OFS_STATUS);

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
      arready <= 1'b1;
    end else if (arvalid & arready) begin
      rvalid  <= 1'b1;
      rdata   <= rdSel;
      rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      arready <= 1'b0;
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Configuration fields
  outMode_t outMode;
  mulSize_t mulSize;
  assign outMode = outMode_t'(ctrl_r[CTRL_MODE +: 3]);
  assign mulSize = mulSize_t'(ctrl_r[CTRL_SIZE +: 2]);
  wire [1:0] signDepth = accCfg_r[CFG_SPIPE +: 2];
  wire [1:0] dirDepth  = accCfg_r[CFG_DPIPE +: 2];
  // Q1.15 rounding and saturation only in 18-bit operation; accumulator rounding and saturation also need signed operands
  wire qAllowed = (mulSize == SIZE_18);

  // Sign and direction control pipelines of selectable depth
  logic [1:0] signPipe1_r;
  logic [1:0] signPipe2_r;
  logic [1:0] dirPipe1_r;
  logic [1:0] dirPipe2_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      signPipe1_r <= 2'b00;
      signPipe2_r <= 2'b00;
      dirPipe1_r  <= 2'b11;
      dirPipe2_r  <= 2'b11;
    end else begin
      signPipe1_r <= {signB, signA};
      signPipe2_r <= signPipe1_r;
      dirPipe1_r  <= {bottomAdderDirection, topAdderDirection};
      dirPipe2_r  <= dirPipe1_r;
    end
  end
  wire [1:0] signNow = (signDepth == 2'd0) ? {signB, signA} :
                       (signDepth == 2'd1) ? signPipe1_r : signPipe2_r;
  wire [1:0] dirNow  = (dirDepth == 2'd0) ? {bottomAdderDirection, topAdderDirection} :
                       (dirDepth == 2'd1) ? dirPipe1_r : dirPipe2_r;
  wire       prodSigned = signNow[0] | signNow[1];

  // Products enter only from the multiplier ports
  wire [71:0] e0 = extProd(prod0, prodSigned);
  wire [71:0] e1 = extProd(prod1, prodSigned);
  wire [71:0] e2 = extProd(prod2, prodSigned);
  wire [71:0] e3 = extProd(prod3, prodSigned);

  // First-level adders: A-B and C-D when subtracting
  wire        rndTop = topAdderRoundEnable & qAllowed;
  wire        rndBot = bottomAdderRoundEnable & qAllowed;
  wire [71:0] topSum = addSub(e0, e1, dirNow[0], rndTop);
  wire [71:0] botSum = addSub(e2, e3, dirNow[1], rndBot);
  wire [71:0] sumAll = topSum + botSum;
  // Narrow mode: four half-width first-level units and two summation adders
  wire [35:0] topLo  = addHalf(prod0[17:0], prod1[17:0], dirNow[0], prodSigned);
  wire [35:0] topHi  = addHalf(prod0[35:18], prod1[35:18], dirNow[0], prodSigned);
  wire [35:0] botLo  = addHalf(prod2[17:0], prod3[17:0], dirNow[1], prodSigned);
  wire [35:0] botHi  = addHalf(prod2[35:18], prod3[35:18], dirNow[1], prodSigned);
  wire [35:0] sumLo  = topLo + botLo;
  wire [35:0] sumHi  = topHi + botHi;
  // 36-bit multiplier: partial products LL, LH, HL, HH combined
  wire [71:0] mul36  = {36'h0, prod0} + ({e1[53:0], 18'h0}) + ({e2[53:0], 18'h0})
                       + {prod3, 36'h0};

  // Accumulators: state lives in the output register stage
  logic [71:0] accState_r [2];
  logic [71:0] result_r   [2];
  logic [1:0]  ovfPrev_r;
  wire  [35:0] preload    [2];
  assign preload[0] = accPreload0;
  assign preload[1] = accPreload1;
  wire  [71:0] prodAcc    [2];
  assign prodAcc[0] = e0;
  assign prodAcc[1] = e2;

  // Output register clock, enable and clear selection
  wire [1:0] regTick;
  wire [1:0] regClear;
  logic [71:0] muxOut [2];
  logic [71:0] accNext [2];
  logic [71:0] accShown [2];
  logic [1:0]  accOvf;
  logic [1:0]  accSatNow;

  for (genvar i = 0; i < 2; i++) begin : g_acc
    wire [7:0]  cfg     = oregCfg_r[i*OREG_STR +: 8];
    assign regTick[i]  = clockTick[cfg[OREG_CLK +: 2]] & clockEna[cfg[OREG_ENA +: 2]];
    assign regClear[i] = clearIn[cfg[OREG_CLR +: 2]];
    wire [1:0]  dirMode = accCfg_r[(i == 0 ? CFG_DIR0 : CFG_DIR1) +: 2];
    wire        accAdd  = (dirMode == DIR_ADD) ? 1'b1 :
                          (dirMode == DIR_SUB) ? 1'b0 : dirNow[i];
    // Reload loads the preload value into the upper bits, shifted up by PRE_SHIFT with zeros below
    wire [71:0] feedback = accSload[i] ? {{20{preload[i][35]}}, preload[i], {PRE_SHIFT{1'b0}}}
                                       : accState_r[i];
    wire [72:0] wide     = accAdd ? {feedback[71], feedback} + {prodAcc[i][71], prodAcc[i]}
                                  : {feedback[71], feedback} - {prodAcc[i][71], prodAcc[i]};
    wire [71:0] accSum   = {{20{wide[ACC_W-1]}}, wide[ACC_W-1:0]};
    assign accOvf[i]  = (wide[ACC_W] != wide[ACC_W-1]);
    assign accNext[i] = accSum;
    // Round and saturate the shown result, state keeps full precision
    wire        doRnd   = accRoundEnable[i] & qAllowed & prodSigned;
    wire        doSat   = accSatEnable[i] & qAllowed & prodSigned;
    wire [71:0] rnded   = doRnd ? ((accSum + RND_ADD) & ~RND_MASK) : accSum;
    wire        outRange = (rnded[71:SAT_TOP] != {(72-SAT_TOP){rnded[SAT_TOP]}});
    assign accSatNow[i] = doSat & outRange;
    // Saturated results carry a one in the lowest bit
    assign accShown[i]  = accSatNow[i] ? ((rnded[71] ? SAT_NEG : SAT_POS) | 72'h1)
                                       : rnded;
  end

  // Output select multiplexer by mode
  always_comb begin
    muxOut[0] = 72'h0;
    muxOut[1] = 72'h0;
    unique case (outMode)
      MODE_SIMPLE: begin
        muxOut[0] = {prod1, prod0};
        muxOut[1] = {prod3, prod2};
      end
      MODE_MAC: begin
        muxOut[0] = accShown[0];
        muxOut[1] = accShown[1];
      end
      MODE_ADD2: begin
        muxOut[0] = (mulSize == SIZE_9) ? {topHi, topLo} : (topSum & ~LOW3_MASK);
        muxOut[1] = (mulSize == SIZE_9) ? {botHi, botLo} : (botSum & ~LOW3_MASK);
      end
      MODE_ADD4: begin
        muxOut[0] = (mulSize == SIZE_9) ? {sumHi, sumLo} : (sumAll & ~LOW3_MASK);
        muxOut[1] = 72'h0;
      end
      MODE_MUL36: begin
        muxOut[0] = mul36;
        muxOut[1] = 72'h0;
      end
      default: begin
        muxOut[0] = 72'h0;
        muxOut[1] = 72'h0;
      end
    endcase
  end

  // Output registers double as accumulator state
  for (genvar i = 0; i < 2; i++) begin : g_oreg
    always_ff @(posedge clk) begin
      if (reset | regClear[i]) begin
        accState_r[i] <= 72'h0;
        result_r[i]   <= 72'h0;
        accSatFlag[i] <= 1'b0;
      end else if (regTick[i]) begin
        accState_r[i] <= (outMode == MODE_MAC) ? accNext[i] : 72'h0;
        result_r[i]   <= muxOut[i];
        accSatFlag[i] <= (outMode == MODE_MAC) & accSatNow[i];
      end
    end
    // Overflow pulses once at the first of detections in consecutive clk cycles
    always_ff @(posedge clk) begin
      if (reset) begin
        ovfPrev_r[i]   <= 1'b0;
        accOverflow[i] <= 1'b0;
      end else begin
        ovfPrev_r[i]   <= (outMode == MODE_MAC) & accOvf[i] & regTick[i];
        accOverflow[i] <= (outMode == MODE_MAC) & accOvf[i] & regTick[i] & ~ovfPrev_r[i];
      end
    end
    // Sticky status bits for software; set wins over read-clear
    always_ff @(posedge clk) begin
      if (reset) begin
        satSeen_r[i] <= 1'b0;
        ovfSeen_r[i] <= 1'b0;
      end else begin
        satSeen_r[i] <= accSatFlag[i] | (satSeen_r[i] & ~statusRead);
        ovfSeen_r[i] <= accOverflow[i] | (ovfSeen_r[i] & ~statusRead);
      end
    end
  end
  assign result0 = result_r[0];
  assign result1 = result_r[1];

  // Checks
  sequence sReload0;
    accSload[0] & regTick[0] & ~regClear[0] & (outMode == MODE_MAC) & ~reset;
  endsequence

  a_ovf_one_cycle: assert property (@(posedge clk) disable iff (reset)
    accOverflow[0] |=> !accOverflow[0])
    else $error("overflow pulse longer than one cycle");
  a_ovf_cause: assert property (@(posedge clk) disable iff (reset)
    accOverflow[1] |-> $past(accOvf[1]) && !$past(ovfPrev_r[1]))
    else $error("overflow pulse without fresh overflow");
  a_reload_value: assert property (@(posedge clk) disable iff (reset)
    sReload0 |=> accState_r[0][51:0] == ($past(g_acc[0].accAdd)
                 ? $past({accPreload0, {PRE_SHIFT{1'b0}}} + e0[51:0])
                 : $past({accPreload0, {PRE_SHIFT{1'b0}}} - e0[51:0])))
    else $error("reload did not load preload plus product");
  a_reload_zero: assert property (@(posedge clk) disable iff (reset)
    sReload0 ##0 (accPreload0 == 36'h0) ##0 g_acc[0].accAdd
      |=> accState_r[0] == $past(e0) && ($past(accNext[0]) == $past(e0)))
    else $error("reload did not restart from zero");
  a_clear_zero: assert property (@(posedge clk) disable iff (reset)
    regClear[1] |=> result_r[1] == 72'h0 && accState_r[1] == 72'h0)
    else $error("clear did not zero output register");
  a_hold_no_tick: assert property (@(posedge clk) disable iff (reset)
    !regTick[0] && !regClear[0] |=> $stable(result_r[0]))
    else $error("output register moved without its clock");
  a_sat_flag_lsb: assert property (@(posedge clk) disable iff (reset)
    accSatFlag[0] |-> result_r[0][0] && (result_r[0][2:1] == 2'b00))
    else $error("saturation flag without saturated value");
  a_q_gated: assert property (@(posedge clk) disable iff (reset)
    (mulSize != SIZE_18) |-> !accSatNow[0] && !accSatNow[1])
    else $error("saturation applied outside Q1.15 mode");
  a_sub_order: assert property (@(posedge clk) disable iff (reset)
    (outMode == MODE_ADD2) && (mulSize == SIZE_18) && !rndTop && !dirNow[0] && regTick[0]
      && !regClear[0] |=> result_r[0] == (($past(e0) - $past(e1)) & ~LOW3_MASK))
    else $error("subtraction order wrong");
  a_axi_bresp: assert property (@(posedge clk) disable iff (reset)
    doWrite |=> bvalid && !awready && !wready)
    else $error("write response missing");

endmodule // dsp_adder_output_stage

// file: ovf_latch.sv
/*
  Fabric-side holder of the accumulator overflow pulses.
  Assumes the pulses are one cycle wide and share clk with the stage.
*/
`timescale 1ns/1ns
module ovf_latch (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] pulse,
  input  wire logic       clr,
  output logic      [1:0] held
);
  always_ff @(posedge clk) begin
    if (reset || clr) held <= 2'b00;
    else held <= held | pulse;
  end
endmodule // ovf_latch

// file: dsp_adder_output_stage_tb.sv
/*
  Self-checking bench for the adder/output stage.
  Assumes the register map and timing of the stage as delivered.
*/
`timescale 1ns/1ns
module dsp_adder_output_stage_tb;
  import dsp_adder_pkg::*;
  logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, signA = 0, signB = 0;
  logic awready, wready, bvalid, arready, rvalid, topDir = 1, botDir = 1, topRnd = 0, ovfClr = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, accSload = 0, accSatEnable = 0, accOverflow, accSatFlag, held;
  logic [PROD_W-1:0] p0 = 0, p1 = 0, p2 = 0, p3 = 0, pre0 = 0;
  logic [3:0] tick = 0, clr = 0;
  logic [RES_W-1:0] result0, result1;
  int err_total = 0, cmp_count = 0, cyc = 0;
  logic [1:0] rsp;
  logic [31:0] rd;
  always #5 clk = ~clk;
  dsp_adder_output_stage u_dsp_adder_output_stage (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .prod0(p0), .prod1(p1), .prod2(p2), .prod3(p3),
    .signA(signA), .signB(signB), .topAdderDirection(topDir), .bottomAdderDirection(botDir),
    .topAdderRoundEnable(topRnd), .bottomAdderRoundEnable(1'b0), .accSload(accSload), .accPreload0(pre0),
    .accPreload1(36'h0), .accRoundEnable(2'b00), .accSatEnable(accSatEnable), .clockTick(tick),
    .clockEna(4'hf), .clearIn(clr), .result0(result0), .result1(result1), .accOverflow(accOverflow),
    .accSatFlag(accSatFlag));
  ovf_latch u_ovf_latch (.clk(clk), .reset(reset), .pulse(accOverflow), .clr(ovfClr), .held(held));
  task automatic report_and_stop();
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [71:0] seen, logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d);
    logic aw, w, b, ah, wh;
    ah = 1; wh = 1; b = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (ah || wh) begin
      @(negedge clk); aw = awready; w = wready;
      @(posedge clk);
      if (aw && ah) begin awvalid <= 0; ah = 0; end
      if (w && wh) begin wvalid <= 0; wh = 0; end
    end
    while (!b) begin
      @(negedge clk); b = bvalid; rsp = bresp;
      @(posedge clk);
    end
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic axr(logic [7:0] a);
    logic ar, r;
    ar = 0; r = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!ar) begin
      @(negedge clk); ar = arready;
      @(posedge clk);
    end
    arvalid <= 0;
    while (!r) begin
      @(negedge clk); r = rvalid; rd = rdata; rsp = rresp;
      @(posedge clk);
    end
    rready <= 0;
    @(posedge clk);
  endtask
  task automatic tk();
    tick <= 4'h1;
    @(posedge clk);
    tick <= 4'h0;
    @(posedge clk);
  endtask
  task automatic t_regs();
    axr(OFS_ACCCFG); chk("acccfg", {40'h0, rd}, {40'h0, ACCCFG_RST});
    axr(8'h10); chk("unmapped", {70'h0, rsp}, {70'h0, RESP_SLVERR});
    axw(8'h14, 32'h1); chk("wr unmapped", {70'h0, rsp}, {70'h0, RESP_SLVERR});
    axw(OFS_OREG, 32'h0); chk("wr okay", {70'h0, rsp}, {70'h0, RESP_OKAY});
  endtask
  task automatic t_modes();
    axw(OFS_CTRL, 32'h0); p0 <= 36'h8; p1 <= 36'h1; p2 <= 36'h2; p3 <= 36'h1; tk();
    chk("simple", result0, {36'h1, 36'h8});
    axw(OFS_CTRL, 32'h4); tk(); chk("mul36", result0, 72'h10000c0008);
    axw(OFS_CTRL, 32'h2); topDir <= 0; botDir <= 0; p0 <= 36'h100; p1 <= 36'h18; p2 <= 36'h40; p3 <= 36'h8; tk();
    chk("sub top", result0, 72'he8);
    chk("sub bottom", result1, 72'h38);
    signA <= 1; signB <= 1; topRnd <= 1; topDir <= 1; p0 <= 36'h40000; p1 <= 36'h8; tk();
    chk("round", result0, 72'h80000);
    axw(OFS_CTRL, 32'h3); topRnd <= 0; botDir <= 1; p1 <= 36'h18; tk();
    chk("sum4", result0, 72'h40060);
    axw(OFS_CTRL, 32'h12); botDir <= 0; p0 <= {18'h3, 18'h5}; p1 <= {18'h1, 18'h2}; tk();
    chk("narrow top", result0, {36'h4, 36'h7});
    chk("narrow bottom", result1, 72'h38);
    axw(OFS_CTRL, 32'h2); axw(OFS_ACCCFG, ACCCFG_RST | (32'h1 << CFG_DPIPE));
    p0 <= 36'h100; p1 <= 36'h18; @(posedge clk);
    topDir <= 0; tk(); chk("dir pipe", result0, 72'h118);
    axw(OFS_ACCCFG, ACCCFG_RST);
  endtask
  task automatic t_mac();
    axw(OFS_CTRL, 32'h1); signA <= 0; signB <= 0; topDir <= 1;
    accSload <= 2'b01; pre0 <= 36'h123; p0 <= 36'h48; tk(); chk("preload", result0, 72'h1230048);
    accSload <= 2'b00; p0 <= 36'h10; tk(); chk("acc add", result0, 72'h1230058);
    topDir <= 0; tk(); chk("acc sub", result0, 72'h1230048);
    axw(OFS_ACCCFG, 32'h9); topDir <= 1; tk(); chk("sub only", result0, 72'h1230038);
    axw(OFS_ACCCFG, ACCCFG_RST);
    topDir <= 1; accSload <= 2'b01; pre0 <= 36'h0; p0 <= 36'h20; tk(); chk("reload", result0, 72'h20);
    accSload <= 2'b00; clr <= 4'h1; @(posedge clk); clr <= 4'h0; @(posedge clk);
    chk("clear", result0, 72'h0);
    signA <= 1; signB <= 1; accSatEnable <= 2'b01; accSload <= 2'b01; pre0 <= 36'h100000; p0 <= 36'h0; tk();
    chk("saturate", result0, 72'h3fffffff9);
    chk("sat flag", {70'h0, accSatFlag}, 72'h1);
    accSatEnable <= 2'b00; pre0 <= 36'h7ffffffff; p0 <= 36'h10000; tk();
    chk("ovf pulse", {70'h0, accOverflow}, 72'h1);
    @(posedge clk); chk("ovf drop", {70'h0, accOverflow}, 72'h0);
    chk("overflow", {70'h0, held}, 72'h1);
    ovfClr <= 1; @(posedge clk); ovfClr <= 0; @(posedge clk);
    chk("ovf latch clr", {70'h0, held}, 72'h0);
    axr(OFS_STATUS); chk("status", {40'h0, rd}, 72'h14);
    axr(OFS_STATUS); chk("status clr", {40'h0, rd}, 72'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_regs();
    t_modes();
    t_mac();
    report_and_stop();
  end
endmodule // dsp_adder_output_stage_tb
